// ===== src/dbg_map.svh
`ifndef DBG_MAP_SVH
`define DBG_MAP_SVH
`define QUEUE_DEPTH      8
`define QUEUE_FULL       4'h8
`define QUEUE_LAST       4'h7
`define QUEUE_EMPTY      4'h0
`define COUNT_STEP       4'h1
`define COF_SKIP_CYCLES  2'h2
`define SKIP_DONE        2'h0
`define SKIP_STEP        2'h1
`define TRACK_DEPTH      3
`define TRACK_EMPTY      2'h0
`define TRACK_FULL       2'h3
`define TRACK_STEP       2'h1
`define BUS_READ         1'b1
`define ZERO_BYTE        8'h00
`define ZERO_WORD        16'h0000
`endif

// ===== src/dbg_pkg.sv
package dbg_pkg;
   typedef enum logic [3:0] {
      TM_A_ONLY          = 4'b0000,
      TM_A_OR_B          = 4'b0001,
      TM_A_THEN_B        = 4'b0010,
      TM_EVENT_B         = 4'b0011,
      TM_A_THEN_EVENT_B  = 4'b0100,
      TM_INSIDE          = 4'b0101,
      TM_OUTSIDE         = 4'b0110,
      TM_A_AND_B_DATA    = 4'b0111,
      TM_A_AND_NOT_B     = 4'b1000
   } trig_mode_e;
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_ARMED = 2'b01,
      ST_TRACE = 2'b10
   } run_state_e;
   typedef enum logic [2:0] {
      COF_NONE     = 3'b000,
      COF_COND     = 3'b001,
      COF_ALWAYS   = 3'b010,
      COF_INDIRECT = 3'b011,
      COF_RETURN   = 3'b100,
      COF_DIRECT   = 3'b101
   } cof_kind_e;
endpackage : dbg_pkg

// ===== src/opcode_tracker.sv
`timescale 1ns/10ps
`default_nettype none
`include "dbg_map.svh"
module opcode_tracker (
   // Clock and reset
   input  wire logic sys_clk,
   input  wire logic rst_n,
   // Instruction queue
   input  wire logic fetch,
   input  wire logic exec,
   input  wire logic flush,
   input  wire logic hit,
   // Qualified match
   output logic      qual
);
   logic [`TRACK_DEPTH-1:0] tag_q;
   logic [1:0]              cnt_q;
   logic [1:0]              pos;
   logic                    pop;

   assign pop  = exec && (cnt_q != `TRACK_EMPTY);
   assign pos  = pop ? cnt_q - `TRACK_STEP : cnt_q;
   // Only the tag at the queue head can qualify
   assign qual = pop && tag_q[0];

   // One tag per queued opcode, so several matches can be in flight
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tag_q <= '0;
         cnt_q <= `TRACK_EMPTY;
      end
      else if (flush)
      begin
         tag_q <= '0;
         cnt_q <= `TRACK_EMPTY;
      end
      else
      begin
         for (int i = 0; i < `TRACK_DEPTH; i++)
         begin
            if (fetch && i == int'(pos))
               tag_q[i] <= hit;
            else if (pop)
               tag_q[i] <= (i == `TRACK_DEPTH - 1) ? 1'b0 : tag_q[(i + 1) % `TRACK_DEPTH];
         end
         if (fetch && !pop && cnt_q != `TRACK_FULL)
            cnt_q <= cnt_q + `TRACK_STEP;
         else if (pop && !fetch)
            cnt_q <= cnt_q - `TRACK_STEP;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   exec_only_a: assert property (qual |-> exec && !flush)
      else $error("tracker qualified without execution");
endmodule : opcode_tracker
`default_nettype wire

// ===== src/bus_trace_trigger_fifo.sv
// Function
// - Eight-entry capture queue holds address or data words, read oldest first.
// - Two 16-bit comparators, each with optional read/write qualification.
// - Opcode qualification: per-comparator tracker, trigger only when opcode executes.
// - Magnitude tests give inside-range and outside-range trigger modes.
// - Comparators suppressed during serial debug controller bus accesses.
// - A compares address; B compares address or data per mode.
// - Full modes use write data when A qualifies writes, else read data.
// - Qualified match breaks, stores data, starts or stops address recording.
// - Word count status tracks valid queue entries as stored.
// - Manual stop before full shifts entries one place; host skips 8-count-1.
// - Address words read high then low; low read advances queue.
// - Event modes store data in low byte; each low read shifts.
// - Begin trigger cycle and next two bus cycles record nothing.
// - End-type trigger that is a change of flow is recorded last.
// - Unarmed low reads push most recent fetched opcode address.
// - Only change-of-flow addresses are recorded in address modes.
// - Taken conditional branch records its own address; always/never record nothing.
// - Indexed indirect jump or call records computed destination.
// - Interrupt entry and returns record destination address.
// - Force breakpoint request held until instruction boundary acknowledged.
// - Tag breakpoint marks opcode as it enters instruction queue.
// - Arm starts run, sets run flag, clears match flags and count.
// - Begin run ends full, end run on trigger; disarm stops any run.
`timescale 1ns/10ps
`default_nettype none
`include "dbg_map.svh"
module bus_trace_trigger_fifo
   import dbg_pkg::*;
(
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   // CPU bus
   input  wire logic [15:0] cpu_addr,
   input  wire logic [7:0]  cpu_rdata,
   input  wire logic [7:0]  cpu_wdata,
   input  wire logic        cpu_rw,
   input  wire logic        cpu_bus_valid,
   input  wire logic        debug_access,
   // Instruction queue
   input  wire logic        opcode_fetch,
   input  wire logic        opcode_exec,
   input  wire logic        queue_flush,
   // Change of flow
   input  wire logic [2:0]  cof_kind,
   input  wire logic [15:0] cof_src_addr,
   input  wire logic [15:0] cof_dst_addr,
   // Control
   input  wire logic        mod_enable,
   input  wire logic        arm_set,
   input  wire logic        arm_clear,
   input  wire logic [3:0]  trig_mode,
   input  wire logic        begin_trace,
   input  wire logic        opcode_qualify_select,
   input  wire logic        brk_enable,
   input  wire logic        brk_tag,
   input  wire logic        brk_ack,
   input  wire logic [15:0] comp_a_value,
   input  wire logic [15:0] comp_b_value,
   input  wire logic        comp_a_rw_qualify_enable,
   input  wire logic        comp_a_rw_match_value,
   input  wire logic        comp_b_rw_qualify_enable,
   input  wire logic        comp_b_rw_match_value,
   // Queue read port
   input  wire logic        queue_rd_low,
   output logic [7:0]       queue_port_high,
   output logic [7:0]       queue_port_low,
   // Status
   output logic             run_active_flag,
   output logic             match_a_flag,
   output logic             match_b_flag,
   output logic [3:0]       queue_word_count,
   // CPU breakpoint
   output logic             brk_force_req,
   output logic             brk_tag_req
);
   trig_mode_e  mode;
   run_state_e  state_q;
   logic [15:0] mem_q [`QUEUE_DEPTH];
   logic [15:0] last_fetch_q;
   logic [15:0] store_word;
   logic [15:0] cof_addr;
   logic [7:0]  b_data;
   logic [1:0]  skip_q;
   logic [1:0]  raw_hit;
   logic [1:0]  trk_hit;
   logic        cmp_live, full_mode, event_mode, rwa_ok, rwb_ok;
   logic        a_raw, b_raw, qa, qb, a_seen_q, trig, tag_hit;
   logic        cof_store, store_en, stop_manual, run_live, brk_force_q;

   assign mode       = trig_mode_e'(trig_mode);
   assign full_mode  = (mode == TM_A_AND_B_DATA) || (mode == TM_A_AND_NOT_B);
   assign event_mode = (mode == TM_EVENT_B) || (mode == TM_A_THEN_EVENT_B);
   assign run_live   = (state_q != ST_IDLE);

   // Debug-controller cycles must never look like user traffic
   assign cmp_live = cpu_bus_valid && !debug_access;
   assign rwa_ok = !comp_a_rw_qualify_enable || (cpu_rw == comp_a_rw_match_value);
   assign rwb_ok = !comp_b_rw_qualify_enable || (cpu_rw == comp_b_rw_match_value);
   // Only a write-qualified A can steer B onto the write bus
   assign b_data = (comp_a_rw_qualify_enable && comp_a_rw_match_value != `BUS_READ)
                   ? cpu_wdata : cpu_rdata;

   always_comb
   begin
      a_raw = 1'b0;
      b_raw = 1'b0;
      case (mode)
         TM_INSIDE:
            a_raw = cmp_live && cpu_addr >= comp_a_value && cpu_addr <= comp_b_value;
         TM_OUTSIDE:
            a_raw = cmp_live && (cpu_addr < comp_a_value || cpu_addr > comp_b_value);
         TM_A_AND_B_DATA:
            a_raw = cmp_live && rwa_ok && cpu_addr == comp_a_value
                    && b_data == comp_b_value[7:0];
         TM_A_AND_NOT_B:
            a_raw = cmp_live && rwa_ok && cpu_addr == comp_a_value
                    && b_data != comp_b_value[7:0];
         default:
         begin
            a_raw = cmp_live && rwa_ok && cpu_addr == comp_a_value;
            b_raw = cmp_live && rwb_ok && cpu_addr == comp_b_value;
         end
      endcase
   end

   assign raw_hit = {b_raw, a_raw};
   for (genvar g = 0; g < 2; g++)
   begin : g_track
      opcode_tracker u_track (
         .sys_clk (sys_clk),
         .rst_n   (rst_n),
         .fetch   (opcode_fetch),
         .exec    (opcode_exec),
         .flush   (queue_flush),
         .hit     (raw_hit[g] && opcode_fetch),
         .qual    (trk_hit[g])
      );
   end
   assign qa = opcode_qualify_select ? trk_hit[0] : raw_hit[0];
   assign qb = opcode_qualify_select ? trk_hit[1] : raw_hit[1];

   always_comb
   begin
      case (mode)
         TM_A_OR_B:         trig = qa || qb;
         TM_A_THEN_B:       trig = a_seen_q && qb;
         TM_EVENT_B:        trig = qb;
         TM_A_THEN_EVENT_B: trig = a_seen_q && qb;
         default:           trig = qa;
      endcase
   end

   // Tag request ignores the data half of full modes
   always_comb
   begin
      case (mode)
         TM_A_OR_B:   tag_hit = a_raw || b_raw;
         TM_EVENT_B:  tag_hit = b_raw;
         TM_A_THEN_B, TM_A_THEN_EVENT_B:
                      tag_hit = a_seen_q && b_raw;
         default:     tag_hit = full_mode ? (cmp_live && rwa_ok && cpu_addr == comp_a_value) : a_raw;
      endcase
   end

   assign cof_store = (cof_kind == COF_COND) || (cof_kind == COF_INDIRECT)
                      || (cof_kind == COF_RETURN);
   assign cof_addr  = (cof_kind == COF_COND) ? cof_src_addr : cof_dst_addr;

   always_comb
   begin
      store_en   = 1'b0;
      store_word = `ZERO_WORD;
      case (state_q)
         ST_ARMED:
         begin
            if (event_mode)
            begin
               store_en   = trig;
               store_word = {`ZERO_BYTE, b_data};
            end
            else if (!begin_trace)
            begin
               // Trigger cycle itself still lands as the last entry
               store_en   = cof_store;
               store_word = cof_addr;
            end
         end
         ST_TRACE:
         begin
            store_en   = cof_store && skip_q == `SKIP_DONE;
            store_word = cof_addr;
         end
         default:
         begin
            store_en   = 1'b0;
            store_word = `ZERO_WORD;
         end
      endcase
   end

   assign stop_manual = run_live && (arm_clear || !mod_enable);

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         state_q <= ST_IDLE;
      else if (arm_set && mod_enable)
         state_q <= ST_ARMED;
      else if (stop_manual)
         state_q <= ST_IDLE;
      else
      begin
         case (state_q)
            ST_ARMED:
               if (event_mode)
               begin
                  if (store_en && queue_word_count == `QUEUE_LAST)
                     state_q <= ST_IDLE;
               end
               else if (trig)
                  state_q <= begin_trace ? ST_TRACE : ST_IDLE;
            ST_TRACE:
               if (store_en && queue_word_count == `QUEUE_LAST)
                  state_q <= ST_IDLE;
            default:
               state_q <= ST_IDLE;
         endcase
      end
   end

   // Begin trigger holds recording off for the next two bus cycles
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         skip_q <= `SKIP_DONE;
      else if (state_q == ST_ARMED && trig && begin_trace && !event_mode)
         skip_q <= `COF_SKIP_CYCLES;
      else if (skip_q != `SKIP_DONE && cpu_bus_valid)
         skip_q <= skip_q - `SKIP_STEP;
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         queue_word_count <= `QUEUE_EMPTY;
      else if (arm_set && mod_enable)
         queue_word_count <= `QUEUE_EMPTY;
      else if (store_en && queue_word_count != `QUEUE_FULL)
         queue_word_count <= queue_word_count + `COUNT_STEP;
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         last_fetch_q <= `ZERO_WORD;
      else if (opcode_fetch)
         last_fetch_q <= cpu_addr;
   end

   // Shift-in queue: newest enters at the top, port shows entry 0
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < `QUEUE_DEPTH; i++)
            mem_q[i] <= `ZERO_WORD;
      end
      else if (store_en || (stop_manual && queue_word_count != `QUEUE_FULL) || queue_rd_low)
      begin
         for (int i = 0; i < `QUEUE_DEPTH - 1; i++)
            mem_q[i] <= mem_q[i+1];
         if (store_en)
            mem_q[`QUEUE_DEPTH-1] <= store_word;
         else if (stop_manual || run_live)
            mem_q[`QUEUE_DEPTH-1] <= `ZERO_WORD;
         else
            mem_q[`QUEUE_DEPTH-1] <= last_fetch_q;
      end
   end
   assign queue_port_high = mem_q[0][15:8];
   assign queue_port_low  = mem_q[0][7:0];

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         match_a_flag <= 1'b0;
         match_b_flag <= 1'b0;
         a_seen_q     <= 1'b0;
      end
      else if (arm_set && mod_enable)
      begin
         match_a_flag <= 1'b0;
         match_b_flag <= 1'b0;
         a_seen_q     <= 1'b0;
      end
      else if (run_live)
      begin
         match_a_flag <= match_a_flag || qa;
         match_b_flag <= match_b_flag || qb;
         a_seen_q     <= a_seen_q || qa;
      end
   end

   // Request stays up until the CPU reaches an instruction boundary; set wins
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         brk_force_q <= 1'b0;
      else if (run_live && brk_enable && !brk_tag && trig)
         brk_force_q <= 1'b1;
      else if (brk_ack)
         brk_force_q <= 1'b0;
   end
   assign brk_force_req   = brk_force_q;
   assign brk_tag_req     = run_live && brk_enable && brk_tag && opcode_fetch && tag_hit;
   assign run_active_flag = run_live;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   debug_quiet_a: assert property (debug_access |-> !a_raw && !b_raw)
      else $error("comparator matched during debug access");
   arm_clears_a: assert property (arm_set && mod_enable |=>
         run_active_flag && queue_word_count == `QUEUE_EMPTY && !match_a_flag)
      else $error("arm did not reset status");
   count_step_a: assert property (store_en && queue_word_count != `QUEUE_FULL && !(arm_set && mod_enable)
         |=> queue_word_count == $past(queue_word_count) + `COUNT_STEP)
      else $error("count did not follow store");
   full_end_a: assert property (state_q == ST_TRACE && store_en && !arm_set
         && queue_word_count == `QUEUE_LAST |=> !run_active_flag)
      else $error("begin run did not end when full");
   skip_two_a: assert property (state_q == ST_ARMED && trig && begin_trace && !event_mode
         && !stop_manual && !arm_set |=> !store_en)
      else $error("change of flow stored right after trigger");
   profile_push_a: assert property (!run_live && queue_rd_low && !arm_set
         |=> mem_q[`QUEUE_DEPTH-1] == $past(last_fetch_q))
      else $error("profile read did not push fetch address");
   write_bus_a: assert property (comp_a_rw_qualify_enable && !comp_a_rw_match_value
         |-> b_data == cpu_wdata)
      else $error("data compare not on write bus");
   force_hold_a: assert property (brk_force_req && !brk_ack |=> brk_force_req)
      else $error("force request dropped early");
   tag_fetch_a: assert property (brk_tag_req |-> opcode_fetch && brk_tag && brk_enable)
      else $error("tag request outside opcode fetch");
   manual_shift_a: assert property (stop_manual && !store_en && !(arm_set && mod_enable)
         && queue_word_count != `QUEUE_FULL |=> mem_q[`QUEUE_DEPTH-1] == `ZERO_WORD)
      else $error("manual stop did not shift queue");
   event_low_a: assert property (store_en && event_mode |-> store_word[15:8] == `ZERO_BYTE)
      else $error("event data reached high byte");
   cof_pick_a: assert property (state_q == ST_TRACE && store_en |-> cof_store
         && store_word == ((cof_kind == COF_COND) ? cof_src_addr : cof_dst_addr))
      else $error("wrong change-of-flow address stored");
endmodule : bus_trace_trigger_fifo
`default_nettype wire

// ===== tb/cpu_bus_model.sv
`timescale 1ns/10ps
`default_nettype none
module cpu_bus_model (
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   // CPU bus and instruction queue
   output logic [15:0]      cpu_addr,
   output logic [7:0]       cpu_rdata,
   output logic [7:0]       cpu_wdata,
   output logic             cpu_rw,
   output logic             cpu_bus_valid,
   output logic             debug_access,
   output logic             opcode_fetch,
   output logic             opcode_exec,
   output logic             queue_flush,
   output logic [2:0]       cof_kind,
   output logic [15:0]      cof_src_addr,
   output logic [15:0]      cof_dst_addr,
   // Breakpoint handshake
   input  wire logic        brk_force_req,
   input  wire logic [3:0]  ack_delay,
   output logic             brk_ack
);
   logic [3:0] wait_q;

   initial
   begin
      {cpu_addr, cpu_rdata, cpu_wdata, cpu_rw, cpu_bus_valid, debug_access, opcode_fetch, opcode_exec,
       queue_flush, cof_kind, cof_src_addr, cof_dst_addr} = '0;
   end

   // Flags are {valid, debug, fetch, exec, flush}
   task automatic cyc(input logic [15:0] a, input logic rw, input logic [7:0] rd, input logic [7:0] wd,
                      input logic [2:0] k, input logic [15:0] ca, input logic [4:0] fl);
      @(posedge sys_clk);
      cpu_addr     <= a;
      cpu_rw       <= rw;
      cpu_rdata    <= rd;
      cpu_wdata    <= wd;
      cof_kind     <= k;
      cof_src_addr <= ca;
      cof_dst_addr <= ~ca;
      {cpu_bus_valid, debug_access, opcode_fetch, opcode_exec, queue_flush} <= fl;
   endtask : cyc

   // Released lines flip so stale values never look valid
   task automatic idle();
      cyc(~cpu_addr, cpu_rw, ~cpu_rdata, ~cpu_wdata, 3'h0, ~cof_src_addr, 5'h00);
   endtask : idle

   // Ack only after a variable instruction tail
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wait_q  <= 4'h0;
         brk_ack <= 1'b0;
      end
      else
      begin
         brk_ack <= 1'b0;
         if (brk_force_req && !brk_ack)
         begin
            wait_q <= wait_q + 4'h1;
            if (wait_q == ack_delay)
            begin
               brk_ack <= 1'b1;
               wait_q  <= 4'h0;
            end
         end
      end
   end
endmodule : cpu_bus_model
`default_nettype wire

// ===== tb/bus_trace_trigger_fifo_tb.sv
`timescale 1ns/10ps
`default_nettype none
module bus_trace_trigger_fifo_tb;
   import dbg_pkg::*;
   typedef struct {
      logic [3:0]  m;
      logic [15:0] a;
      logic        rw;
      logic [7:0]  rd;
      logic [7:0]  wd;
      logic        dbg;
      logic        t;
   } case_s;
   logic        sys_clk, rst_n, mod_enable, arm_set, arm_clear, begin_trace, brk_ack;
   logic        opcode_qualify_select, brk_enable, brk_tag, queue_rd_low, brk_force_req, brk_tag_req;
   logic        comp_a_rw_qualify_enable, comp_a_rw_match_value, comp_b_rw_qualify_enable, comp_b_rw_match_value;
   logic        cpu_rw, cpu_bus_valid, debug_access, opcode_fetch, opcode_exec, queue_flush;
   logic        run_active_flag, match_a_flag, match_b_flag;
   logic [2:0]  cof_kind;
   logic [3:0]  trig_mode, queue_word_count, ack_delay;
   logic [7:0]  cpu_rdata, cpu_wdata, queue_port_high, queue_port_low;
   logic [15:0] cpu_addr, cof_src_addr, cof_dst_addr, comp_a_value, comp_b_value;
   int          err_count, comparisons, i;
   case_s       tbl [16];

   cpu_bus_model i_cpu (.*);
   bus_trace_trigger_fifo i_dut (.*);

   initial
   begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   task automatic chk(input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp)
      begin
         err_count++;
         $display("CHECK FAILED at %0t: expected %h got %h", $time, exp, got);
      end
   endtask : chk

   task automatic flag(input logic e);
      @(negedge sys_clk);
      chk({15'h0, e}, {15'h0, run_active_flag});
   endtask : flag

   // Flags are {brk_enable, brk_tag, opcode_qualify_select}
   task automatic arm(input logic [3:0] m, input logic b, input logic [2:0] f);
      @(posedge sys_clk);
      trig_mode   <= m;
      begin_trace <= b;
      {brk_enable, brk_tag, opcode_qualify_select} <= f;
      arm_set     <= 1'b1;
      @(posedge sys_clk);
      arm_set <= 1'b0;
      flag(1'b1);
      chk(16'h0000, {10'h0, match_a_flag, match_b_flag, queue_word_count});
   endtask : arm

   task automatic stop();
      @(posedge sys_clk);
      arm_clear <= 1'b1;
      @(posedge sys_clk);
      arm_clear <= 1'b0;
      flag(1'b0);
   endtask : stop

   // High byte is sampled before the low strobe advances the queue
   task automatic rd(input logic [15:0] exp, input logic en);
      @(negedge sys_clk);
      if (en)
         chk(exp, {queue_port_high, queue_port_low});
      @(posedge sys_clk);
      queue_rd_low <= 1'b1;
      @(posedge sys_clk);
      queue_rd_low <= 1'b0;
   endtask : rd

   task automatic gap(input int n);
      repeat (n) i_cpu.idle();
   endtask : gap

   task automatic results();
      $display("comparisons %0d err_count %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : results

   initial
   begin
      repeat (20000) @(posedge sys_clk);
      err_count++;
      results();
   end

   initial
   begin
      {arm_set, arm_clear, begin_trace, opcode_qualify_select, brk_enable, brk_tag, queue_rd_low, rst_n} = '0;
      {comp_a_rw_match_value, comp_b_rw_qualify_enable, comp_b_rw_match_value} = '0;
      comp_a_rw_qualify_enable = 1'b1;
      mod_enable   = 1'b1;
      trig_mode    = 4'h0;
      ack_delay    = 4'h3;
      comp_a_value = 16'h3000;
      comp_b_value = 16'h30FF;
      tbl = '{'{TM_A_ONLY, 16'h3000, 1'b0, 8'h00, 8'h00, 1'b0, 1'b1}, '{TM_A_ONLY, 16'h3000, 1'b0, 8'h00, 8'h00, 1'b1, 1'b0},
              '{TM_A_ONLY, 16'h3000, 1'b1, 8'h00, 8'h00, 1'b0, 1'b0}, '{TM_A_ONLY, 16'h3001, 1'b0, 8'h00, 8'h00, 1'b0, 1'b0},
              '{TM_A_OR_B, 16'h30FF, 1'b0, 8'h00, 8'h00, 1'b0, 1'b1}, '{TM_INSIDE, 16'h2FFF, 1'b0, 8'h00, 8'h00, 1'b0, 1'b0},
              '{TM_INSIDE, 16'h3000, 1'b0, 8'h00, 8'h00, 1'b0, 1'b1}, '{TM_INSIDE, 16'h30FF, 1'b0, 8'h00, 8'h00, 1'b0, 1'b1},
              '{TM_INSIDE, 16'h3100, 1'b0, 8'h00, 8'h00, 1'b0, 1'b0}, '{TM_OUTSIDE, 16'h3050, 1'b0, 8'h00, 8'h00, 1'b0, 1'b0},
              '{TM_OUTSIDE, 16'h2FFF, 1'b0, 8'h00, 8'h00, 1'b0, 1'b1}, '{TM_OUTSIDE, 16'h3100, 1'b0, 8'h00, 8'h00, 1'b0, 1'b1},
              '{TM_A_AND_B_DATA, 16'h3000, 1'b0, 8'h00, 8'hFF, 1'b0, 1'b1},
              '{TM_A_AND_B_DATA, 16'h3000, 1'b0, 8'hFF, 8'h00, 1'b0, 1'b0},
              '{TM_A_AND_NOT_B, 16'h3000, 1'b0, 8'hFF, 8'hFF, 1'b0, 1'b0},
              '{TM_A_AND_NOT_B, 16'h3000, 1'b0, 8'hFF, 8'h00, 1'b0, 1'b1}};
      repeat (20) @(posedge sys_clk);
      rst_n <= 1'b1;
      flag(1'b0);
      chk(16'h0000, {queue_port_high, queue_port_low});
      // Arm without module enable must be ignored
      @(posedge sys_clk);
      mod_enable <= 1'b0;
      arm_set    <= 1'b1;
      @(posedge sys_clk);
      mod_enable <= 1'b1;
      arm_set    <= 1'b0;
      flag(1'b0);
      $display("test reset done");
      i_cpu.cyc(16'h4321, 1'b0, 8'h00, 8'h00, 3'h0, 16'h0000, 5'h14);
      i_cpu.idle();
      repeat (8) rd(16'h0000, 1'b0);
      rd(16'h4321, 1'b1);
      $display("test profile done");
      arm(TM_EVENT_B, 1'b0, 3'b000);
      for (i = 0; i < 9; i++)
         i_cpu.cyc(16'h30FF, 1'b0, 8'hA0 + i[7:0], 8'hA0 + i[7:0], 3'h0, 16'h0000, 5'h10);
      gap(2);
      flag(1'b0);
      chk(16'h0008, {12'h0, queue_word_count});
      for (i = 0; i < 8; i++)
         rd({8'h00, 8'hA0 + i[7:0]}, 1'b1);
      $display("test event done");
      arm(TM_A_ONLY, 1'b0, 3'b100);
      for (i = 1; i < 6; i++)
         i_cpu.cyc(16'h1000, 1'b0, 8'h00, 8'h00, i[2:0], 16'hC000 + i[15:0] * 16'h0101, 5'h10);
      i_cpu.cyc(16'h3000, 1'b0, 8'h00, 8'h00, 3'h0, 16'h0000, 5'h18);
      i_cpu.cyc(16'h3000, 1'b0, 8'h00, 8'h00, 3'h1, 16'h3000, 5'h10);
      i_cpu.idle();
      flag(1'b0);
      chk(16'h0004, {12'h0, queue_word_count});
      chk(16'h0003, {14'h0, match_a_flag, brk_force_req});
      for (i = 0; i < 12 && brk_force_req === 1'b1; i++)
         @(negedge sys_clk);
      chk(16'h0000, {15'h0, brk_force_req});
      repeat (4) rd(16'h0000, 1'b0);
      rd(16'hC101, 1'b1);
      rd(16'h3CFC, 1'b1);
      rd(16'h3BFB, 1'b1);
      rd(16'h3000, 1'b1);
      $display("test end trace done");
      arm(TM_A_ONLY, 1'b1, 3'b000);
      i_cpu.cyc(16'h3000, 1'b0, 8'h00, 8'h00, 3'h1, 16'h3000, 5'h10);
      for (i = 1; i < 5; i++)
         i_cpu.cyc(16'h1000, 1'b0, 8'h00, 8'h00, (i == 4) ? 3'h3 : 3'h1, 16'hD000 + i[15:0] * 16'h0101, 5'h10);
      i_cpu.idle();
      flag(1'b1);
      chk(16'h0002, {12'h0, queue_word_count});
      stop();
      repeat (5) rd(16'h0000, 1'b0);
      rd(16'hD303, 1'b1);
      rd(16'h2BFB, 1'b1);
      $display("test begin trace done");
      for (i = 0; i < 16; i++)
      begin
         arm(tbl[i].m, 1'b0, 3'b000);
         i_cpu.cyc(tbl[i].a, tbl[i].rw, tbl[i].rd, tbl[i].wd, 3'h0, 16'h0000, {1'b1, tbl[i].dbg, 3'h0});
         gap(3);
         flag(~tbl[i].t);
         chk({15'h0, (tbl[i].m == TM_A_OR_B) && tbl[i].t}, {15'h0, match_b_flag});
         stop();
      end
      // B before A must not trigger in sequence modes
      arm(TM_A_THEN_B, 1'b0, 3'b000);
      i_cpu.cyc(16'h30FF, 1'b0, 8'h00, 8'h00, 3'h0, 16'h0000, 5'h10);
      gap(2);
      flag(1'b1);
      i_cpu.cyc(16'h3000, 1'b0, 8'h00, 8'h00, 3'h0, 16'h0000, 5'h10);
      i_cpu.cyc(16'h30FF, 1'b0, 8'h00, 8'h00, 3'h0, 16'h0000, 5'h10);
      i_cpu.idle();
      flag(1'b0);
      arm(TM_A_THEN_EVENT_B, 1'b0, 3'b000);
      i_cpu.cyc(16'h30FF, 1'b0, 8'h00, 8'h55, 3'h0, 16'h0000, 5'h10);
      i_cpu.cyc(16'h3000, 1'b0, 8'h00, 8'h00, 3'h0, 16'h0000, 5'h10);
      i_cpu.cyc(16'h30FF, 1'b0, 8'h00, 8'h66, 3'h0, 16'h0000, 5'h10);
      gap(2);
      chk(16'h0001, {12'h0, queue_word_count});
      stop();
      $display("test compare done");
      arm(TM_A_ONLY, 1'b0, 3'b111);
      i_cpu.cyc(16'h3000, 1'b0, 8'h00, 8'h00, 3'h0, 16'h0000, 5'h14);
      @(negedge sys_clk);
      chk(16'h0001, {15'h0, brk_tag_req});
      i_cpu.cyc(16'h1000, 1'b0, 8'h00, 8'h00, 3'h0, 16'h0000, 5'h01);
      i_cpu.cyc(16'h1000, 1'b0, 8'h00, 8'h00, 3'h0, 16'h0000, 5'h12);
      gap(3);
      flag(1'b1);
      i_cpu.cyc(16'h3000, 1'b0, 8'h00, 8'h00, 3'h0, 16'h0000, 5'h14);
      i_cpu.cyc(16'h1000, 1'b0, 8'h00, 8'h00, 3'h0, 16'h0000, 5'h12);
      gap(3);
      flag(1'b0);
      stop();
      $display("test opcode done");
      results();
   end
endmodule : bus_trace_trigger_fifo_tb
`default_nettype wire
